// ===== verilog/cdrc_pkg.sv
/*
 Package for the recovery-loop mode controller: modes, timing, structs.
 Assumes a 100 MHz system clock.
*/
package cdrc_pkg;

   localparam int unsigned CLK_MHZ = 100;
   // Least lock-to-data wait, in microseconds
   localparam int unsigned LOCK_MIN_US = 4;
   localparam int unsigned LOCK_MIN_CYC = LOCK_MIN_US * CLK_MHZ;
   // Longest wait for a stable recovered clock, in microseconds
   localparam int unsigned STABLE_MAX_US = 1000;
   localparam int unsigned STABLE_MAX_CYC = STABLE_MAX_US * CLK_MHZ;
   // Phase window in thousandths of a unit interval
   localparam logic [7:0] PHASE_WIN_MUI = 8'h50;
   localparam logic [15:0] PPM_THR_RST = 16'h03e8;

   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h1;
   localparam logic [3:0] ADDR_IRQ = 4'h2;
   localparam logic [3:0] ADDR_MASK = 4'h3;
   localparam logic [3:0] ADDR_PPM = 4'h4;

   // Control register bit positions
   localparam int unsigned CTRL_MANUAL = 0;
   localparam int unsigned CTRL_F_DATA = 1;
   localparam int unsigned CTRL_F_REF = 2;
   localparam int unsigned CTRL_PCIE = 3;
   localparam int unsigned CTRL_TXPLL = 4;
   localparam int unsigned CTRL_PORTSEL = 5;
   localparam logic [5:0] CTRL_RST = 6'h00;

   // Event bits: 0 entered data mode, 1 left data mode, 2 clock stable
   localparam int unsigned EV_W = 3;

   typedef enum logic [1:0] {
      CDRC_REF = 2'b00,
      CDRC_DATA = 2'b01,
      CDRC_STABLE = 2'b10
   } cdrc_state_e;

   typedef struct packed {
      logic freq_ok;
      logic phase_ok;
      logic sig_det;
      logic pll_ref_locked;
   } cdrc_loop_s;

   typedef struct packed {
      logic force_data;
      logic force_ref;
   } cdrc_force_s;

endpackage

// ===== verilog/cdrc_lock_timer.sv
/*
 Down counter timing lock intervals after data-tracking entry.
 Assumes start pulses only come from the controller state machine.
*/
`timescale 1ns/1ns
module cdrc_lock_timer #(
   parameter int unsigned WIDTH = 24
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Control
   input wire logic clear_i,
   input wire logic start_i,
   input wire logic [WIDTH-1:0] load_i,
   // Status
   output logic done_o
);

   logic [WIDTH-1:0] cnt_q;
   logic run_q;
   logic done_q;
   wire last_w = run_q && (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || clear_i) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end else if (start_i) begin
         cnt_q <= load_i;
         run_q <= 1'b1;
         done_q <= 1'b0;
      end else if (run_q) begin
         cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
         run_q <= !last_w;
         done_q <= last_w;
      end
   end

   assign done_o = done_q;

endmodule

// ===== verilog/cdrc_ctrl.sv
/*
 Recovery-loop mode controller: picks reference or data tracking,
 reports both lock flags, times the stable-clock indication and keeps
 a small register file with sticky events and a level interrupt.
 Assumes loop status inputs are synchronous to clock_i and that the
 analog reset input is already synchronous.
*/
`timescale 1ns/1ns
module cdrc_ctrl #(
   parameter int unsigned STABLE_CYC = cdrc_pkg::STABLE_MAX_CYC,
   parameter int unsigned MIN_CYC = cdrc_pkg::LOCK_MIN_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic analog_rst_i,
   // Loop status from the analog side
   input wire cdrc_pkg::cdrc_loop_s loop_i,
   // Force controls from user ports
   input wire cdrc_pkg::cdrc_force_s force_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Loop control and flags
   output logic data_mode_o,
   output logic ref_lock_flag_o,
   output logic data_lock_flag_o,
   output logic data_lock_min_o,
   output logic clock_stable_o,
   output logic irq_o
);

   localparam int unsigned TW = 24;

   cdrc_pkg::cdrc_state_e state_q, state_d;
   logic [5:0] ctrl_q;
   logic [15:0] ppm_thr_q;
   logic [cdrc_pkg::EV_W-1:0] irq_stat_q, irq_mask_q, ev_w;
   logic [31:0] rdata_q;
   logic ref_lock_q, data_lock_q, min_q, stable_q, irq_q;
   logic min_done_w, stable_done_w;

   function automatic logic sel_bit(input logic [3:0] a, input logic [3:0] b);
      sel_bit = (a == b);
   endfunction

   // Register decode
   wire wr_ctrl_w = reg_wr_i && sel_bit(reg_addr_i, cdrc_pkg::ADDR_CTRL);
   wire wr_irq_w = reg_wr_i && sel_bit(reg_addr_i, cdrc_pkg::ADDR_IRQ);
   wire wr_mask_w = reg_wr_i && sel_bit(reg_addr_i, cdrc_pkg::ADDR_MASK);
   wire wr_ppm_w = reg_wr_i && sel_bit(reg_addr_i, cdrc_pkg::ADDR_PPM);

   // Force sources: register bits or ports
   wire manual_w = ctrl_q[cdrc_pkg::CTRL_MANUAL];
   wire pcie_w = ctrl_q[cdrc_pkg::CTRL_PCIE];
   wire txpll_w = ctrl_q[cdrc_pkg::CTRL_TXPLL];
   wire port_sel_w = ctrl_q[cdrc_pkg::CTRL_PORTSEL];
   wire f_data_w = port_sel_w ? force_i.force_data : ctrl_q[cdrc_pkg::CTRL_F_DATA];
   wire f_ref_w = port_sel_w ? force_i.force_ref : ctrl_q[cdrc_pkg::CTRL_F_REF];

   wire auto_enter_w = loop_i.freq_ok && loop_i.phase_ok && (!pcie_w || loop_i.sig_det);
   // exit on drift, or on signal loss in PCIe mode
   wire auto_exit_w = !loop_i.freq_ok || (pcie_w && !loop_i.sig_det);
   wire man_data_w = f_data_w && !f_ref_w;
   wire want_data_w = manual_w ? man_data_w : auto_enter_w;
   wire keep_data_w = manual_w ? man_data_w : !auto_exit_w;
   wire hold_ref_w = analog_rst_i || txpll_w;
   wire in_data_w = (state_q != cdrc_pkg::CDRC_REF);
   wire enter_w = (state_q == cdrc_pkg::CDRC_REF) && (state_d == cdrc_pkg::CDRC_DATA);

   always_comb begin
      state_d = state_q;
      case (state_q)
         cdrc_pkg::CDRC_REF: begin
            if (!hold_ref_w && want_data_w) begin
               state_d = cdrc_pkg::CDRC_DATA;
            end
         end
         cdrc_pkg::CDRC_DATA: begin
            if (hold_ref_w || !keep_data_w) begin
               state_d = cdrc_pkg::CDRC_REF;
            end else if (stable_done_w) begin
               state_d = cdrc_pkg::CDRC_STABLE;
            end
         end
         cdrc_pkg::CDRC_STABLE: begin
            if (hold_ref_w || !keep_data_w) begin
               state_d = cdrc_pkg::CDRC_REF;
            end
         end
         default: begin
            state_d = cdrc_pkg::CDRC_REF;
         end
      endcase
   end

   wire leave_w = in_data_w && (state_d == cdrc_pkg::CDRC_REF);
   assign ev_w = {stable_done_w && (state_q == cdrc_pkg::CDRC_DATA) && !leave_w,
      leave_w, enter_w};

   cdrc_lock_timer #(.WIDTH(TW)) u_min_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .clear_i(leave_w),
      .start_i(enter_w),
      .load_i(TW'(MIN_CYC)),
      .done_o(min_done_w)
   );

   cdrc_lock_timer #(.WIDTH(TW)) u_stable_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .clear_i(leave_w),
      .start_i(enter_w),
      .load_i(TW'(STABLE_CYC)),
      .done_o(stable_done_w)
   );

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_q <= cdrc_pkg::CDRC_REF;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         data_lock_q <= 1'b0;
         ref_lock_q <= 1'b0;
         min_q <= 1'b0;
         stable_q <= 1'b0;
      end else begin
         data_lock_q <= (state_d != cdrc_pkg::CDRC_REF);
         ref_lock_q <= loop_i.pll_ref_locked;
         min_q <= (state_d != cdrc_pkg::CDRC_REF) && (min_q || min_done_w) && !enter_w;
         stable_q <= (state_d == cdrc_pkg::CDRC_STABLE);
      end
   end

   // Control and threshold registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctrl_q <= cdrc_pkg::CTRL_RST;
         ppm_thr_q <= cdrc_pkg::PPM_THR_RST;
         irq_mask_q <= '0;
      end else begin
         if (wr_ctrl_w) begin
            ctrl_q <= reg_wdata_i[5:0];
         end
         if (wr_ppm_w) begin
            ppm_thr_q <= reg_wdata_i[15:0];
         end
         if (wr_mask_w) begin
            irq_mask_q <= reg_wdata_i[cdrc_pkg::EV_W-1:0];
         end
      end
   end

   // Sticky events, set beats write-one clear
   wire [cdrc_pkg::EV_W-1:0] clr_w = wr_irq_w ? reg_wdata_i[cdrc_pkg::EV_W-1:0] : '0;
   wire [cdrc_pkg::EV_W-1:0] stat_d = (irq_stat_q & ~clr_w) | ev_w;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         irq_stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         irq_stat_q <= stat_d;
         irq_q <= |(stat_d & irq_mask_q);
      end
   end

   // Read data, one cycle after the strobe
   wire [31:0] stat_word_w = {26'h0000000, stable_q, min_q, data_lock_q, ref_lock_q,
      state_q};
   logic [31:0] rd_mux_w;
   always_comb begin
      case (reg_addr_i)
         cdrc_pkg::ADDR_CTRL: rd_mux_w = {26'h0000000, ctrl_q};
         cdrc_pkg::ADDR_STAT: rd_mux_w = stat_word_w;
         cdrc_pkg::ADDR_IRQ: rd_mux_w = {29'h00000000, irq_stat_q};
         cdrc_pkg::ADDR_MASK: rd_mux_w = {29'h00000000, irq_mask_q};
         cdrc_pkg::ADDR_PPM: rd_mux_w = {16'h0000, ppm_thr_q};
         default: rd_mux_w = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else if (reg_rd_i) begin
         rdata_q <= rd_mux_w;
      end else begin
         rdata_q <= '0;
      end
   end

   logic data_mode_q;
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         data_mode_q <= 1'b0;
      end else begin
         data_mode_q <= (state_d != cdrc_pkg::CDRC_REF);
      end
   end

   assign reg_rdata_o = rdata_q;
   assign data_mode_o = data_mode_q;
   assign ref_lock_flag_o = ref_lock_q;
   assign data_lock_flag_o = data_lock_q;
   assign data_lock_min_o = min_q;
   assign clock_stable_o = stable_q;
   assign irq_o = irq_q;

endmodule

// ===== sim/cdrc_ctrl_asserts.sv
/*
 Port checker for the mode controller.
 Assumes a bind onto cdrc_ctrl.
*/
`timescale 1ns/1ns
module cdrc_ctrl_asserts #(
   parameter int unsigned STABLE_CYC = 50,
   parameter int unsigned MIN_CYC = 10
) (
   // Watched ports
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic analog_rst_i,
   input wire cdrc_pkg::cdrc_loop_s loop_i,
   input wire cdrc_pkg::cdrc_force_s force_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic data_mode_o,
   input wire logic ref_lock_flag_o,
   input wire logic data_lock_flag_o,
   input wire logic data_lock_min_o,
   input wire logic clock_stable_o
);
   logic [5:0] ctrl_q;
   int unsigned dm_q;
   logic fd, fr, go, blk, may_enter;
   assign fd = ctrl_q[5] ? force_i.force_data : ctrl_q[1];
   assign fr = ctrl_q[5] ? force_i.force_ref : ctrl_q[2];
   assign go = loop_i.freq_ok && loop_i.phase_ok && (!ctrl_q[3] || loop_i.sig_det);
   assign blk = analog_rst_i || ctrl_q[4];
   // Entry allowed by the active mode source
   assign may_enter = !blk && (ctrl_q[0] ? (fd && !fr) : go);
   // Shadow of control writes, cycles in data mode
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctrl_q <= 6'h00;
      end else if (reg_wr_i && reg_addr_i == cdrc_pkg::ADDR_CTRL) begin
         ctrl_q <= reg_wdata_i[5:0];
      end
      dm_q <= (!rst_n_i || !data_mode_o) ? 0 : dm_q + 1;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_flag_tracks_mode: assert property (data_lock_flag_o == data_mode_o)
      else $error("lock flag differs from mode");
   a_auto_enter: assert property (!ctrl_q[0] && !blk && go |=> data_mode_o)
      else $error("no data entry");
   a_auto_hold: assert property (!ctrl_q[0] && !data_mode_o && !go |=> !data_mode_o)
      else $error("early data entry");
   a_auto_exit: assert property (!ctrl_q[0] && (!loop_i.freq_ok ||
      (ctrl_q[3] && !loop_i.sig_det)) |=> !data_mode_o)
      else $error("no fall back");
   a_enter_cause: assert property ($rose(data_lock_flag_o) |-> $past(may_enter))
      else $error("data mode without cause");
   a_block_ref: assert property (blk |=> !data_mode_o)
      else $error("data mode while blocked");
   a_force_ref: assert property (ctrl_q[0] && fr |=> !data_mode_o)
      else $error("reference force lost");
   a_force_data: assert property (ctrl_q[0] && fd && !fr && !blk |=> data_mode_o)
      else $error("data force lost");
   a_min_wait: assert property (data_lock_min_o |-> dm_q >= MIN_CYC)
      else $error("min flag early");
   a_stable_wait: assert property (clock_stable_o |-> dm_q >= STABLE_CYC)
      else $error("stable flag early");
   a_ref_copy: assert property (!data_mode_o |->
      ref_lock_flag_o == $past(loop_i.pll_ref_locked))
      else $error("ref flag stale");
   c_enter: cover property ($rose(data_mode_o));
   c_exit: cover property ($fell(data_mode_o));
   c_stable: cover property ($rose(clock_stable_o));
endmodule

// ===== sim/cdrc_seq_model.sv
/*
 Reset sequencer and user flag consumer model.
 Assumes flags from the controller on the same clock.
*/
`timescale 1ns/1ns
module cdrc_seq_model (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Controller flags
   input wire logic ref_lock_flag_i,
   input wire logic data_lock_flag_i,
   input wire logic clock_stable_i,
   // Sequencer outputs
   output logic coding_rst_o,
   output logic ref_ok_o
);
   always_ff @(posedge clock_i) begin
      coding_rst_o <= !rst_n_i || !(data_lock_flag_i && clock_stable_i);
   end
   // ref flag only in reference mode
   assign ref_ok_o = ref_lock_flag_i && !data_lock_flag_i;
endmodule

// ===== sim/testbench.sv
/*
 Self-checking bench for the mode controller.
 Assumes the checker and sequencer model compiled first.
*/
`timescale 1ns/1ns
module testbench;
   localparam int unsigned ST = 50;
   localparam int unsigned MN = 10;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic analog_rst_i = 1'b0;
   cdrc_pkg::cdrc_loop_s loop_i = '0;
   cdrc_pkg::cdrc_force_s force_i = '0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o, r;
   logic data_mode_o, ref_lock_flag_o, data_lock_flag_o, data_lock_min_o;
   logic clock_stable_o, irq_o, coding_rst_o, ref_ok_o;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [5:0] tc [4] = '{6'h07, 6'h03, 6'h21, 6'h21};
   logic [1:0] tf [4] = '{2'b00, 2'b00, 2'b11, 2'b10};
   cdrc_ctrl #(.STABLE_CYC(ST), .MIN_CYC(MN)) u_cdrc_ctrl (.clock_i, .rst_n_i,
      .analog_rst_i, .loop_i, .force_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .data_mode_o, .ref_lock_flag_o, .data_lock_flag_o,
      .data_lock_min_o, .clock_stable_o, .irq_o);
   cdrc_seq_model u_cdrc_seq_model (.clock_i, .rst_n_i, .coding_rst_o, .ref_ok_o,
      .ref_lock_flag_i(ref_lock_flag_o), .data_lock_flag_i(data_lock_flag_o),
      .clock_stable_i(clock_stable_o));
   initial forever #5 clock_i = ~clock_i;
   task automatic give_verdict;
      if (n_fail == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Manual mode result: reference force wins
   function automatic logic man_exp(input logic [5:0] c, input logic [1:0] f);
      logic fd;
      logic fr;
      fd = c[cdrc_pkg::CTRL_PORTSEL] ? f[1] : c[cdrc_pkg::CTRL_F_DATA];
      fr = c[cdrc_pkg::CTRL_PORTSEL] ? f[0] : c[cdrc_pkg::CTRL_F_REF];
      man_exp = c[cdrc_pkg::CTRL_MANUAL] && fd && !fr;
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 chk("rdata", reg_rdata_o, e);
   endtask
   task automatic drive(input logic [3:0] v);
      @(posedge clock_i);
      loop_i <= v;
   endtask
   task automatic settle;
      repeat (3) @(posedge clock_i);
      #1;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         give_verdict;
      end
   end
   initial begin
      void'($urandom(96140));
      repeat (12) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(cdrc_pkg::ADDR_STAT, 32'h0);
      rd(cdrc_pkg::ADDR_PPM, 32'h3e8);
      rd(4'hf, 32'h0);
      r = $urandom;
      wr(cdrc_pkg::ADDR_PPM, r);
      rd(cdrc_pkg::ADDR_PPM, {16'h0, r[15:0]});
      wr(cdrc_pkg::ADDR_MASK, 32'h7);
      drive(4'b1001);
      settle;
      chk("flag", data_lock_flag_o, 0);
      chk("ref_ok", ref_ok_o, 1);
      drive(4'b1101);
      settle;
      chk("flag", data_lock_flag_o, 1);
      chk("ref_ok", ref_ok_o, 0);
      chk("min", data_lock_min_o, 0);
      chk("coding_rst", coding_rst_o, 1);
      chk("irq", irq_o, 1);
      rd(cdrc_pkg::ADDR_IRQ, 32'h1);
      wr(cdrc_pkg::ADDR_IRQ, 32'h1);
      settle;
      chk("irq", irq_o, 0);
      repeat (ST + 5) @(posedge clock_i);
      #1 chk("min", data_lock_min_o, 1);
      chk("stable", clock_stable_o, 1);
      chk("coding_rst", coding_rst_o, 0);
      drive(4'b0101);
      settle;
      chk("flag", data_lock_flag_o, 0);
      rd(cdrc_pkg::ADDR_IRQ, 32'h6);
      wr(cdrc_pkg::ADDR_IRQ, 32'h7);
      wr(cdrc_pkg::ADDR_CTRL, 32'h8);
      drive(4'b1100);
      settle;
      chk("flag", data_lock_flag_o, 0);
      drive(4'b1110);
      settle;
      chk("flag", data_lock_flag_o, 1);
      drive(4'b1100);
      settle;
      chk("flag", data_lock_flag_o, 0);
      drive(4'b1110);
      analog_rst_i <= 1'b1;
      settle;
      chk("flag", data_lock_flag_o, 0);
      wr(cdrc_pkg::ADDR_CTRL, 32'h18);
      analog_rst_i <= 1'b0;
      settle;
      chk("flag", data_lock_flag_o, 0);
      drive(4'b0001);
      for (int i = 0; i < 4; i++) begin
         wr(cdrc_pkg::ADDR_CTRL, {26'h0, tc[i]});
         force_i <= tf[i];
         settle;
         chk("flag", data_lock_flag_o, {31'h0, man_exp(tc[i], tf[i])});
      end
      drive(4'b0101);
      force_i <= 2'b01;
      settle;
      chk("flag", data_lock_flag_o, 0);
      for (int i = 0; i < 300; i++) begin
         @(posedge clock_i);
         loop_i <= 4'($urandom);
         force_i <= 2'($urandom);
         analog_rst_i <= ($urandom % 16) == 0;
         if (i % 16 == 0) begin
            wr(cdrc_pkg::ADDR_CTRL, $urandom);
         end
      end
      give_verdict;
   end
endmodule
bind cdrc_ctrl cdrc_ctrl_asserts #(.STABLE_CYC(STABLE_CYC), .MIN_CYC(MIN_CYC))
   u_cdrc_ctrl_asserts (.clock_i, .rst_n_i, .analog_rst_i, .loop_i, .force_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .data_mode_o, .ref_lock_flag_o,
   .data_lock_flag_o, .data_lock_min_o, .clock_stable_o);
